//--- rtl/config_switch_latch.sv
// Configuration switch latch: takes the four-position switch once after
// power-up reset, decodes it to custom mode or one of four locked presets,
// and exposes status and the settings word over APB.
// Assumes presetn is the power-up reset and the switch pins are asynchronous.
//
// Summary of operation
// - Sample switch once after power-up reset
// - Later switch changes ignored until next reset
// - Position four never affects decoding
// - Invalid three-position codes select custom mode
// - Preset locks settings, writes refused
// - Custom mode lets host write settings
// - Decode table: none, 1, 2, 1+2, 3
`timescale 1ns/10ps
`default_nettype none
module config_switch_latch
    import cfg_latch_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration switch pins
    input wire logic select_pos_one,
    input wire logic select_pos_two,
    input wire logic select_pos_three,
    input wire logic reserved_pos_four,
    // Captured configuration
    output logic config_valid,
    output logic custom_en,
    output logic [1:0] preset_idx,
    output logic [31:0] settings_word
);

    // ========================================================================
    // Declarations
    // ========================================================================
    logic [3:0] sw_sync;
    latch_state_e state_ff;
    latch_state_e nxt_state;
    logic [3:0] settle_cnt_ff;
    logic [3:0] sw_cap_ff;
    logic cfg_valid_ff;
    logic custom_en_ff;
    logic [1:0] preset_idx_ff;
    logic [31:0] settings_ff;
    logic [7:0] refused_cnt_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic nxt_custom;
    logic [1:0] nxt_idx;
    logic [31:0] nxt_word;
    logic apb_setup;
    logic apb_access;
    logic hit_status;
    logic hit_settings;
    logic hit_refused;
    logic write_allowed;
    logic wr_settings_ok;
    logic wr_settings_bad;
    logic [31:0] read_mux;

    // ========================================================================
    // Switch synchroniser
    // ========================================================================
    switch_sync u_switch_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({reserved_pos_four, select_pos_three, select_pos_two, select_pos_one}),
        .pin_sync(sw_sync)
    );

    // ========================================================================
    // Switch decode
    // ========================================================================
    // Only positions one to three reach the decoder
    always_comb begin
        nxt_custom = 1'b1;
        nxt_idx = IDX_PRESET1;
        nxt_word = CUSTOM_DEFAULT;
        case (sw_sync[2:0])
            SW_PRESET1: begin
                nxt_custom = 1'b0;
                nxt_idx = IDX_PRESET1;
                nxt_word = PRESET1_WORD;
            end
            SW_PRESET2: begin
                nxt_custom = 1'b0;
                nxt_idx = IDX_PRESET2;
                nxt_word = PRESET2_WORD;
            end
            SW_PRESET3: begin
                nxt_custom = 1'b0;
                nxt_idx = IDX_PRESET3;
                nxt_word = PRESET3_WORD;
            end
            SW_PRESET4: begin
                nxt_custom = 1'b0;
                nxt_idx = IDX_PRESET4;
                nxt_word = PRESET4_WORD;
            end
            default: begin
                // All-off and every unlisted code fall back to custom
                nxt_custom = 1'b1;
                nxt_idx = IDX_PRESET1;
                nxt_word = CUSTOM_DEFAULT;
            end
        endcase
    end

    // ========================================================================
    // Capture sequencer
    // ========================================================================
    // Settle lets the synchroniser fill before the one and only sample
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_SETTLE: begin
                if (settle_cnt_ff == SETTLE_CYCLES) begin
                    nxt_state = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                nxt_state = ST_LOCKED;
            end
            ST_LOCKED: begin
                nxt_state = ST_LOCKED;
            end
            default: begin
                nxt_state = ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_SETTLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Settle counter stops once the sample is due
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt_ff <= 4'h0;
        end else if (state_ff == ST_SETTLE && settle_cnt_ff != SETTLE_CYCLES) begin
            settle_cnt_ff <= settle_cnt_ff + 4'h1;
        end
    end

    // Captured code and decode result, loaded once; only reset reopens it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_cap_ff <= 4'h0;
            cfg_valid_ff <= 1'b0;
            custom_en_ff <= 1'b0;
            preset_idx_ff <= IDX_PRESET1;
        end else if (state_ff == ST_CAPTURE) begin
            sw_cap_ff <= sw_sync;
            cfg_valid_ff <= 1'b1;
            custom_en_ff <= nxt_custom;
            preset_idx_ff <= nxt_idx;
        end
    end

    // ========================================================================
    // APB decode
    // ========================================================================
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable && pready_ff;
    assign hit_status = (paddr == ADDR_STATUS);
    assign hit_settings = (paddr == ADDR_SETTINGS);
    assign hit_refused = (paddr == ADDR_REFUSED);
    // Host edits only in custom mode and only after the sample is taken
    assign write_allowed = cfg_valid_ff && custom_en_ff;
    assign wr_settings_ok = apb_access && pwrite && hit_settings && write_allowed;
    assign wr_settings_bad = apb_access && pwrite && hit_settings && !write_allowed;

    // ========================================================================
    // Settings word
    // ========================================================================
    // Preset loads its fixed word; custom starts from the default word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settings_ff <= CUSTOM_DEFAULT;
        end else if (state_ff == ST_CAPTURE) begin
            settings_ff <= nxt_word;
        end else if (wr_settings_ok) begin
            settings_ff <= pwdata;
        end
    end

    // Refused edits are counted, saturating so it never wraps to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused_cnt_ff <= 8'h00;
        end else if (wr_settings_bad && refused_cnt_ff != REFUSED_MAX) begin
            refused_cnt_ff <= refused_cnt_ff + 8'h01;
        end
    end

    // ========================================================================
    // APB answer
    // ========================================================================
    always_comb begin
        read_mux = 32'h0000_0000;
        if (hit_status) begin
            read_mux[STAT_VALID_BIT] = cfg_valid_ff;
            read_mux[STAT_CUSTOM_BIT] = custom_en_ff;
            read_mux[STAT_IDX_LSB +: 2] = preset_idx_ff;
            read_mux[STAT_SW_LSB +: 4] = sw_cap_ff;
        end else if (hit_settings) begin
            read_mux = settings_ff;
        end else if (hit_refused) begin
            read_mux[7:0] = refused_cnt_ff;
        end
    end

    // Answer prepared in setup so pready and data are flops, no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (apb_setup) begin
            pready_ff <= 1'b1;
            prdata_ff <= pwrite ? 32'h0000_0000 : read_mux;
            // Unmapped address, or a settings write before the sample or while a preset is locked
            pslverr_ff <= !(hit_status || hit_settings || hit_refused) ||
                          (pwrite && hit_settings && !write_allowed);
        end else begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign config_valid = cfg_valid_ff;
    assign custom_en = custom_en_ff;
    assign preset_idx = preset_idx_ff;
    assign settings_word = settings_ff;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_capture;
        state_ff == ST_CAPTURE;
    endsequence

    sequence seq_settings_write;
        psel && !penable && pwrite && hit_settings ##1 psel && penable && pready_ff;
    endsequence

    a_capture_once: assert property (seq_capture |=>
        cfg_valid_ff && state_ff == ST_LOCKED ##1 state_ff == ST_LOCKED)
        else $error("capture did not lock the configuration");

    a_switch_ignored: assert property (
        state_ff == ST_LOCKED && $past(state_ff) == ST_LOCKED |-> $stable(sw_cap_ff))
        else $error("captured switch code changed after lock");

    a_pos_four_ignored: assert property (seq_capture |=>
        custom_en_ff == (($past(sw_sync[2:0]) == SW_CUSTOM) ||
                         ($past(sw_sync[2:0]) > SW_PRESET4)))
        else $error("custom flag depends on more than positions one to three");

    a_invalid_custom: assert property (
        seq_capture and (sw_sync[2:0] > SW_PRESET4) |=> custom_en_ff && cfg_valid_ff)
        else $error("invalid switch code did not select custom mode");

    a_preset_refuse: assert property (
        cfg_valid_ff && !custom_en_ff ##0 seq_settings_write |->
        pslverr_ff ##1 $stable(settings_ff))
        else $error("settings write accepted while a preset is locked");

    a_custom_write: assert property (
        cfg_valid_ff && custom_en_ff ##0 seq_settings_write |->
        !pslverr_ff ##1 settings_ff == $past(pwdata))
        else $error("custom settings write not stored");

    a_decode_table: assert property (
        seq_capture and (sw_sync[2:0] == SW_PRESET3) |=>
        !custom_en_ff && preset_idx_ff == IDX_PRESET3 && settings_ff == PRESET3_WORD)
        else $error("preset three code decoded wrongly");

    a_held_constant: assert property (
        cfg_valid_ff [*2] |-> $stable(preset_idx_ff) && $stable(custom_en_ff))
        else $error("captured selection changed before reset");

    a_apb_answer: assert property (
        psel && !penable |=> pready_ff ##1 !pready_ff)
        else $error("apb answer not given in the first access cycle");

endmodule : config_switch_latch
`default_nettype wire

//--- rtl/cfg_latch_pkg.sv
// Constants, field layout and state type for the configuration switch latch.
// Assumes a 100 MHz pclk and a 32-bit APB register port with byte addresses.
package cfg_latch_pkg;

    // ========================================================================
    // Clock and timing
    // ========================================================================
    localparam int CLK_PERIOD_NS = 10;
    // Settling time after reset release before the switch code is taken
    localparam int SETTLE_TIME_NS = 80;
    localparam logic [3:0] SETTLE_CYCLES =
        4'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ========================================================================
    // Register byte addresses
    // ========================================================================
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_SETTINGS = 8'h04;
    localparam logic [7:0] ADDR_REFUSED = 8'h08;

    // ========================================================================
    // Status register fields
    // ========================================================================
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_CUSTOM_BIT = 1;
    localparam int STAT_IDX_LSB = 2;
    localparam int STAT_SW_LSB = 4;

    // ========================================================================
    // Switch codes: bit 0 is position one, bit 2 position three
    // ========================================================================
    localparam logic [2:0] SW_CUSTOM = 3'h0;
    localparam logic [2:0] SW_PRESET1 = 3'h1;
    localparam logic [2:0] SW_PRESET2 = 3'h2;
    localparam logic [2:0] SW_PRESET3 = 3'h3;
    localparam logic [2:0] SW_PRESET4 = 3'h4;

    // Encoded preset index, preset one is index zero
    localparam logic [1:0] IDX_PRESET1 = 2'h0;
    localparam logic [1:0] IDX_PRESET2 = 2'h1;
    localparam logic [1:0] IDX_PRESET3 = 2'h2;
    localparam logic [1:0] IDX_PRESET4 = 2'h3;

    // ========================================================================
    // Settings words: preset contents and custom default (arbitrary values)
    // ========================================================================
    localparam logic [31:0] PRESET1_WORD = 32'h0000_0011;
    localparam logic [31:0] PRESET2_WORD = 32'h0000_0022;
    localparam logic [31:0] PRESET3_WORD = 32'h0000_0033;
    localparam logic [31:0] PRESET4_WORD = 32'h0000_0044;
    localparam logic [31:0] CUSTOM_DEFAULT = 32'h0000_0000;

    localparam logic [7:0] REFUSED_MAX = 8'hFF;

    // ========================================================================
    // Capture sequencer states
    // ========================================================================
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_CAPTURE = 2'b01,
        ST_LOCKED = 2'b10
    } latch_state_e;

endpackage : cfg_latch_pkg

//--- rtl/switch_sync.sv
// Two-stage synchroniser for the four switch pins.
// Assumes pins are quasi-static levels unrelated to pclk.
`timescale 1ns/10ps
`default_nettype none
module switch_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw pins and synchronised levels
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_sync
);

    // ========================================================================
    // Synchroniser stages
    // ========================================================================
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 4'h0;
            sync_ff <= 4'h0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign pin_sync = sync_ff;

endmodule : switch_sync
`default_nettype wire

//--- testbench/dip_switch_model.sv
// Behavioural model of the four-position configuration switch.
// Assumes the bench only moves the contacts through the override inputs.
`timescale 1ns/10ps
`default_nettype none
module dip_switch_model (
    // Bench override of the contact setting
    input wire logic ovr_en,
    input wire logic [3:0] ovr_code,
    // Switch contacts, bit 0 of the code is position one
    output logic select_pos_one,
    output logic select_pos_two,
    output logic select_pos_three,
    output logic reserved_pos_four
);
    // ========================================================================
    // Contact levels
    // ========================================================================
    // Factory setting until the installer moves it: position one on
    localparam logic [3:0] SHIPPED_CODE = 4'h1;

    // Static levels; a real switch has no idle or released state
    logic [3:0] contacts;
    assign contacts = ovr_en ? ovr_code : SHIPPED_CODE;
    assign select_pos_one = contacts[0];
    assign select_pos_two = contacts[1];
    assign select_pos_three = contacts[2];
    assign reserved_pos_four = contacts[3];
endmodule : dip_switch_model
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the configuration switch latch.
// Assumes the switch model above and APB with one wait-free access cycle.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
    num_checks++; \
    if ((gt) !== (ex)) begin \
        err_total++; \
        $display("Error %s expected %h seen %h", nm, (ex), (gt)); \
    end \
end
module tb_top
    import cfg_latch_pkg::*;
();
    // ========================================================================
    // Signals
    // ========================================================================
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ovr_en = 1'b0;
    logic [3:0] ovr_code = 4'h0;
    logic [31:0] prdata, settings_word;
    logic pready, pslverr, config_valid, custom_en;
    logic [1:0] preset_idx;
    wire logic select_pos_one, select_pos_two, select_pos_three, reserved_pos_four;
    int err_total = 0;
    int num_checks = 0;
    logic [31:0] rng = 32'hC8A9;

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // ========================================================================
    // Instances
    // ========================================================================
    dip_switch_model dip_switch_model_i (
        .ovr_en(ovr_en), .ovr_code(ovr_code),
        .select_pos_one(select_pos_one), .select_pos_two(select_pos_two),
        .select_pos_three(select_pos_three), .reserved_pos_four(reserved_pos_four)
    );
    config_switch_latch config_switch_latch_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .select_pos_one(select_pos_one), .select_pos_two(select_pos_two),
        .select_pos_three(select_pos_three), .reserved_pos_four(reserved_pos_four),
        .config_valid(config_valid), .custom_en(custom_en),
        .preset_idx(preset_idx), .settings_word(settings_word)
    );

    // ========================================================================
    // Helpers
    // ========================================================================
    // Xorshift keeps runs repeatable without a seeded library call
    function automatic logic [31:0] next_rand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : next_rand

    // Expected {custom, index}; position four never enters the decode
    function automatic logic [2:0] exp_cfg(input logic [3:0] code);
        case (code[2:0])
            3'h1: return {1'b0, 2'h0};
            3'h2: return {1'b0, 2'h1};
            3'h3: return {1'b0, 2'h2};
            3'h4: return {1'b0, 2'h3};
            default: return {1'b1, 2'h0};
        endcase
    endfunction : exp_cfg

    // Expected settings word right after capture
    function automatic logic [31:0] exp_word(input logic [3:0] code);
        case (code[2:0])
            3'h1: return PRESET1_WORD;
            3'h2: return PRESET2_WORD;
            3'h3: return PRESET3_WORD;
            3'h4: return PRESET4_WORD;
            default: return CUSTOM_DEFAULT;
        endcase
    endfunction : exp_word

    task automatic close_out();
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // One APB transfer; an edge passes first so psel never toggles twice at once
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            err_total++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // ========================================================================
    // Main sequence: every switch code, then random codes
    // ========================================================================
    initial begin
        logic [31:0] rd, d;
        logic er;
        logic [3:0] code;
        logic [2:0] cfg;
        int i, n;
        for (i = 0; i < 21; i++) begin
            // First pass keeps the shipped setting untouched
            if (i == 0) code = 4'h1;
            else if (i <= 16) code = 4'(i - 1);
            else code = 4'(next_rand() & 32'hF);
            if (i > 0) begin
                ovr_en <= 1'b1;
                ovr_code <= code;
            end
            @(posedge pclk);
            presetn <= 1'b0;
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
            // Settings write before the sample must be refused
            apb(1'b1, ADDR_SETTINGS, 32'hA5, rd, er);
            `CHK("early write err", 1'b1, er)
            for (n = 0; n < 50 && config_valid !== 1'b1; n++) @(posedge pclk);
            if (n == 50) begin
                err_total++;
                close_out();
            end
            cfg = exp_cfg(code);
            `CHK("custom_en", cfg[2], custom_en)
            `CHK("preset_idx", cfg[1:0], preset_idx)
            `CHK("settings_word", exp_word(code), settings_word)
            if (i == 0) `CHK("shipped idx", {1'b0, IDX_PRESET1}, {custom_en, preset_idx})
            apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
            `CHK("status", {24'h0, code, cfg[1:0], cfg[2], 1'b1}, rd)
            d = next_rand();
            apb(1'b1, ADDR_SETTINGS, d, rd, er);
            `CHK("write err", ~cfg[2], er)
            apb(1'b0, ADDR_SETTINGS, 32'h0, rd, er);
            `CHK("settings read", (cfg[2] ? d : exp_word(code)), rd)
            apb(1'b0, ADDR_REFUSED, 32'h0, rd, er);
            `CHK("refused count", 32'(cfg[2] ? 1 : 2), rd)
            apb(1'b0, 8'h0C, 32'h0, rd, er);
            `CHK("unmapped", {1'b1, 32'h0}, {er, rd})
            // Move the switch after capture; nothing may follow it
            ovr_en <= 1'b1;
            ovr_code <= 4'(next_rand() & 32'hF);
            repeat (20) @(posedge pclk);
            `CHK("held flags", {1'b1, cfg}, {config_valid, custom_en, preset_idx})
            `CHK("held word", (cfg[2] ? d : exp_word(code)), settings_word)
        end
        close_out();
    end
endmodule : tb_top
`undef CHK
`default_nettype wire
